// >>> pkg/dps_pkg.sv
// Constants and field layout for the drive protection supervisor
package dps_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int AW = 8;
  localparam int LIM_W = 20;
  localparam int NT = 7;
  // Qualification timer slots
  localparam int T_ULW = 0;
  localparam int T_ULF = 1;
  localparam int T_OVS = 2;
  localparam int T_SDV = 3;
  localparam int T_ENC = 4;
  localparam int T_UV = 5;
  localparam int T_NM = 6;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_ULDLY = 8'h04;
  localparam logic [7:0] A_ULRAT = 8'h08;
  localparam logic [7:0] A_OVS = 8'h0C;
  localparam logic [7:0] A_SDEV = 8'h10;
  localparam logic [7:0] A_ENCUV = 8'h14;
  localparam logic [7:0] A_STOP = 8'h18;
  localparam logic [7:0] A_NOMOT = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_CAPT = 8'h24;
  localparam logic [7:0] A_CMD = 8'h28;
  localparam logic [7:0] A_OFUNC = 8'h2C;
  localparam logic [7:0] A_IFUNC = 8'h30;
  // Control word bit positions
  localparam int C_ULACT = 0;
  localparam int C_ULWEN = 2;
  localparam int C_VEC = 3;
  localparam int C_SDEN = 4;
  localparam int C_ENCEN = 5;
  localparam int C_FANM = 6;
  localparam int C_OPTACT = 7;
  localparam int C_NMEN = 9;
  localparam int C_LV2 = 10;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_04B5;
  localparam logic [31:0] ULDLY_RST = 32'h012C_0064;
  localparam logic [31:0] ULRAT_RST = 32'h0000_1E1E;
  localparam logic [31:0] OVS_RST = 32'h0001_2EE0;
  localparam logic [31:0] SDEV_RST = 32'h000A_07D0;
  localparam logic [31:0] ENCUV_RST = 32'h0000_000A;
  localparam logic [31:0] STOP_RST = 32'h001E_0000;
  localparam logic [31:0] NOMOT_RST = 32'h001E_0005;
  // Action and function codes
  localparam logic [1:0] ACT_COAST = 2'h1;
  localparam logic [1:0] ACT_RAMP = 2'h2;
  localparam logic [7:0] FN_UL_WARN = 8'h06;
  localparam logic [7:0] FN_FAN_WARN = 8'h08;
  localparam logic [7:0] FN_LV_WARN = 8'h0B;
  localparam logic [3:0] IN_FN_RST = 4'h3;
  localparam logic [3:0] IN_FN_BLK = 4'h5;
  // Ratio limits in percent
  localparam logic [7:0] LF_MIN = 8'h0A;
  localparam logic [7:0] LF_MAX = 8'h1E;
  localparam logic [7:0] BF_MIN = 8'h0A;
  localparam logic [7:0] BF_MAX = 8'h64;
  localparam logic [LIM_W-1:0] TICKS_PER_DS = 20'h0000A;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dps_pkg

// >>> pkg/dps_qual_if.sv
// Link between the supervisor and one qualification timer
`timescale 1ns/1ns
interface dps_qual_if;
  import dps_pkg::*;
  logic cond;
  logic tick;
  logic [LIM_W-1:0] limit;
  logic done;
  modport ctl (output cond, output tick, output limit, input done);
  modport tmr (input cond, input tick, input limit, output done);
endinterface : dps_qual_if

// >>> design/dps_tick.sv
// Free-running prescaler giving one-cycle time base ticks
`timescale 1ns/1ns
module dps_tick import dps_pkg::*; #(
  parameter int unsigned CYC = TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Time base
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } dps_tick_t;
  dps_tick_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= CYC - 1) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : dps_tick

// >>> design/dps_qual_timer.sv
// Persistence timer: done once its condition held for limit ticks
`timescale 1ns/1ns
module dps_qual_timer import dps_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Condition and limit
  dps_qual_if.tmr q
);
  typedef struct packed {
    logic [LIM_W-1:0] cnt;
    logic done;
  } dps_qtmr_t;
  dps_qtmr_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!q.cond) begin
      s_d = '0;
    end else if (s_q.cnt >= q.limit) begin
      s_d.done = 1'b1;
    end else if (q.tick) begin
      s_d.cnt = s_q.cnt + 20'h00001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q.done = s_q.done & q.cond;
endmodule : dps_qual_timer

// >>> design/dps_supervisor.sv
// Drive protection supervisor with AXI4-Lite register file
`timescale 1ns/1ns
module dps_supervisor import dps_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Drive measurements, 0.01 Hz and percent
  input wire logic run_cmd,
  input wire logic running,
  input wire logic esave_active,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_current,
  input wire logic [7:0] current_pct,
  input wire logic [7:0] load_pct,
  input wire logic [15:0] rated_slip,
  input wire logic [15:0] base_freq,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] speed_dev,
  // Status inputs
  input wire logic enc_card_present,
  input wire logic enc_line_lost,
  input wire logic fan_fault,
  input wire logic over_temp,
  input wire logic dc_bus_low,
  input wire logic opt_fault,
  input wire logic keypad_reset,
  input wire logic [7:0] mfi_pins,
  // Drive commands
  output logic out_block,
  output logic ramp_stop,
  output logic [15:0] ramp_time,
  output logic accel_enable,
  output logic [2:0] mfo
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] uldly;
    logic [31:0] ulrat;
    logic [31:0] ovs;
    logic [31:0] sdev;
    logic [31:0] encuv;
    logic [31:0] stop;
    logic [31:0] nomot;
    logic [31:0] ofunc;
    logic [31:0] ifunc;
    logic [31:0] capt;
    logic [10:0] flt;
    logic bx_lvl;
    logic rst_lvl;
    logic blk;
    logic ramp;
    logic [15:0] rtime;
    logic accel;
    logic [2:0] mfo;
    logic aw_have;
    logic w_have;
    logic [AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dps_state_t;

  // Fault slots, latched except F_UV and F_BX, which follow their sources
  localparam int F_UL = 0;
  localparam int F_OVS = 1;
  localparam int F_SDV = 2;
  localparam int F_ENC = 3;
  localparam int F_FAN = 4;
  localparam int F_HEAT = 5;
  localparam int F_LV2 = 6;
  localparam int F_NM = 7;
  localparam int F_OPT = 8;
  localparam int F_UV = 9;
  localparam int F_BX = 10;

  localparam dps_state_t S_RST = '{
    ctrl: CTRL_RST, uldly: ULDLY_RST, ulrat: ULRAT_RST,
    ovs: OVS_RST, sdev: SDEV_RST, encuv: ENCUV_RST,
    stop: STOP_RST, nomot: NOMOT_RST,
    awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, default: '0};

  dps_state_t s_q, s_d;
  logic tick;
  logic [NT-1:0] done;
  logic [NT-1:0] cond;
  logic [LIM_W-1:0] lim [NT];

  dps_qual_if qi [NT] ();

  dps_tick #(.CYC(TICK_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    assign qi[i].cond = cond[i];
    assign qi[i].tick = tick;
    assign qi[i].limit = lim[i];
    assign done[i] = qi[i].done;
    dps_qual_timer u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .q(qi[i])
    );
  end

  function automatic logic [LIM_W-1:0] ds(input logic [15:0] v);
    return LIM_W'(v) * TICKS_PER_DS;
  endfunction : ds

  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Underload threshold in percent, interpolated between the two points
  logic [7:0] ul_thr;
  always_comb begin
    int lo_f;
    int lf;
    int bf;
    int thr;
    lo_f = 2 * int'(rated_slip);
    lf = int'(s_q.ulrat[7:0]);
    bf = int'(s_q.ulrat[15:8]);
    thr = lf;
    if (int'(out_freq) <= lo_f) begin
      thr = lf;
    end else if (out_freq >= base_freq) begin
      thr = bf;
    end else begin
      thr = lf + ((bf - lf) * (int'(out_freq) - lo_f)) /
            (int'(base_freq) - lo_f);
    end
    ul_thr = 8'(thr);
  end

  logic ul_low;
  assign ul_low = running & ~esave_active & (load_pct < ul_thr);

  always_comb begin
    cond[T_ULW] = ul_low & s_q.ctrl[C_ULWEN];
    cond[T_ULF] = ul_low & (s_q.ctrl[C_ULACT +: 2] != 2'h0);
    cond[T_OVS] = s_q.ctrl[C_VEC] & (motor_speed > s_q.ovs[15:0]);
    cond[T_SDV] = s_q.ctrl[C_VEC] & s_q.ctrl[C_SDEN] &
                  (speed_dev > s_q.sdev[15:0]);
    cond[T_ENC] = s_q.ctrl[C_ENCEN] &
                  (~enc_card_present | enc_line_lost);
    cond[T_UV] = dc_bus_low;
    cond[T_NM] = run_cmd & s_q.ctrl[C_NMEN] &
                 (current_pct < s_q.nomot[7:0]);
    lim[T_ULW] = ds(s_q.uldly[15:0]);
    lim[T_ULF] = ds(s_q.uldly[31:16]);
    lim[T_OVS] = LIM_W'(s_q.ovs[31:16]);
    lim[T_SDV] = ds(s_q.sdev[31:16]);
    lim[T_ENC] = ds(s_q.encuv[15:0]);
    lim[T_UV] = ds(s_q.encuv[31:16]);
    lim[T_NM] = ds(s_q.nomot[31:16]);
  end

  always_comb begin
    logic sw_rst;
    logic rst_req;
    logic bx_in;
    logic rst_in;
    logic [10:0] ev;
    logic [1:0] ulact;
    logic [1:0] optact;
    logic hard;
    logic trip_ramp;
    logic ulw;
    logic fanw;
    logic [7:0] code;
    logic [31:0] v;
    s_d = s_q;
    sw_rst = 1'b0;
    bx_in = 1'b0;
    rst_in = 1'b0;
    ev = '0;
    ulact = s_q.ctrl[C_ULACT +: 2];
    optact = s_q.ctrl[C_OPTACT +: 2];
    code = '0;
    v = '0;
    rst_req = 1'b0;
    hard = 1'b0;
    trip_ramp = 1'b0;
    ulw = 1'b0;
    fanw = 1'b0;

    // Write channel: address and data may arrive in either order
    if (awvalid & s_q.awrdy) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid & s_q.wrdy) begin
      s_d.w_have = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid & bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_d.aw_have & s_d.w_have & ~s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_d.awaddr)
        A_CTRL: s_d.ctrl = merge(s_q.ctrl, s_d.wdata, s_d.wstrb);
        A_ULDLY: s_d.uldly = merge(s_q.uldly, s_d.wdata, s_d.wstrb);
        A_ULRAT: begin
          v = merge(s_q.ulrat, s_d.wdata, s_d.wstrb);
          s_d.ulrat = {16'h0000, clamp(v[15:8], BF_MIN, BF_MAX),
                       clamp(v[7:0], LF_MIN, LF_MAX)};
        end
        A_OVS: s_d.ovs = merge(s_q.ovs, s_d.wdata, s_d.wstrb);
        A_SDEV: s_d.sdev = merge(s_q.sdev, s_d.wdata, s_d.wstrb);
        A_ENCUV: s_d.encuv = merge(s_q.encuv, s_d.wdata, s_d.wstrb);
        A_STOP: s_d.stop = merge(s_q.stop, s_d.wdata, s_d.wstrb);
        A_NOMOT: s_d.nomot = merge(s_q.nomot, s_d.wdata, s_d.wstrb);
        A_OFUNC: s_d.ofunc = merge(s_q.ofunc, s_d.wdata, s_d.wstrb);
        A_IFUNC: s_d.ifunc = merge(s_q.ifunc, s_d.wdata, s_d.wstrb);
        A_CMD: sw_rst = s_d.wstrb[0] & s_d.wdata[0];
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    // Ready drops while a half or a response is pending
    s_d.awrdy = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wrdy = ~s_d.w_have & ~s_d.bvalid;

    // Read channel, one outstanding read
    if (s_q.rvalid & rready) begin
      s_d.rvalid = 1'b0;
      s_d.arrdy = 1'b1;
    end
    if (arvalid & s_q.arrdy) begin
      s_d.arrdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      case (araddr)
        A_CTRL: s_d.rdata = s_q.ctrl;
        A_ULDLY: s_d.rdata = s_q.uldly;
        A_ULRAT: s_d.rdata = s_q.ulrat;
        A_OVS: s_d.rdata = s_q.ovs;
        A_SDEV: s_d.rdata = s_q.sdev;
        A_ENCUV: s_d.rdata = s_q.encuv;
        A_STOP: s_d.rdata = s_q.stop;
        A_NOMOT: s_d.rdata = s_q.nomot;
        A_OFUNC: s_d.rdata = s_q.ofunc;
        A_IFUNC: s_d.rdata = s_q.ifunc;
        A_CMD: s_d.rdata = '0;
        A_STAT: s_d.rdata = {14'h0000, s_q.ramp, s_q.blk, s_q.accel,
                             s_q.mfo, 1'b0, s_q.flt};
        A_CAPT: s_d.rdata = s_q.capt;
        default: begin
          s_d.rdata = '0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Multi-function inputs
    for (int i = 0; i < 8; i++) begin
      if (mfi_pins[i] & (s_q.ifunc[4*i +: 4] == IN_FN_BLK)) begin
        bx_in = 1'b1;
      end
      if (mfi_pins[i] & (s_q.ifunc[4*i +: 4] == IN_FN_RST)) begin
        rst_in = 1'b1;
      end
    end
    s_d.bx_lvl = bx_in;
    s_d.rst_lvl = rst_in;
    rst_req = keypad_reset | (rst_in & ~s_q.rst_lvl) | sw_rst;

    // Capture on the block input edge during operation
    if (bx_in & ~s_q.bx_lvl & running) begin
      s_d.capt = {out_current, out_freq};
    end

    // Fault events
    ev[F_UL] = done[T_ULF];
    ev[F_OVS] = done[T_OVS];
    ev[F_SDV] = done[T_SDV];
    ev[F_ENC] = done[T_ENC];
    ev[F_FAN] = fan_fault & ~s_q.ctrl[C_FANM];
    ev[F_HEAT] = over_temp;
    ev[F_LV2] = s_q.ctrl[C_LV2] & dc_bus_low & running;
    ev[F_NM] = done[T_NM];
    ev[F_OPT] = opt_fault & (optact != 2'h0);
    // A new event outweighs a reset arriving in the same cycle
    s_d.flt[8:0] = (s_q.flt[8:0] & ~{9{rst_req}}) | ev[8:0];
    s_d.flt[F_UV] = done[T_UV];
    s_d.flt[F_BX] = bx_in;

    // Output decision; coasting outranks any ramp
    hard = s_d.flt[F_OVS] | s_d.flt[F_SDV] | s_d.flt[F_ENC] |
           s_d.flt[F_FAN] | s_d.flt[F_HEAT] | s_d.flt[F_LV2] |
           s_d.flt[F_NM] | s_d.flt[F_UV];
    trip_ramp = (s_d.flt[F_UL] & (ulact == ACT_RAMP)) |
                (s_d.flt[F_OPT] & (optact == ACT_RAMP));
    s_d.blk = hard | dc_bus_low |
              (s_d.flt[F_UL] & (ulact == ACT_COAST)) |
              (s_d.flt[F_OPT] & (optact == ACT_COAST)) |
              (bx_in & (s_q.stop[15:0] == 16'h0000));
    s_d.ramp = ~s_d.blk &
               (trip_ramp | (bx_in & (s_q.stop[15:0] != 16'h0000)));
    if (trip_ramp) begin
      s_d.rtime = s_q.stop[31:16];
    end else begin
      s_d.rtime = s_q.stop[15:0];
    end
    s_d.accel = run_cmd & ~bx_in & ~s_d.blk & ~s_d.ramp &
                (s_d.flt[8:0] == 9'h000);

    // Multi-function outputs
    ulw = done[T_ULW];
    fanw = fan_fault & s_q.ctrl[C_FANM];
    for (int i = 0; i < 3; i++) begin
      code = s_q.ofunc[8*i +: 8];
      s_d.mfo[i] = ((code == FN_UL_WARN) & ulw) |
                   ((code == FN_FAN_WARN) & fanw) |
                   ((code == FN_LV_WARN) & dc_bus_low);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = s_q.awrdy;
  assign wready = s_q.wrdy;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arrdy;
  assign rvalid = s_q.rvalid;
  assign rresp = s_q.rresp;
  assign rdata = s_q.rdata;
  assign out_block = s_q.blk;
  assign ramp_stop = s_q.ramp;
  assign ramp_time = s_q.rtime;
  assign accel_enable = s_q.accel;
  assign mfo = s_q.mfo;
endmodule : dps_supervisor

// >>> test/dps_drive_model.sv
// Power stage and operator stand-in facing the supervisor
`timescale 1ns/1ns
module dps_drive_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // From the supervisor
  input wire logic out_block,
  // Operator side
  input wire logic run_cmd,
  input wire logic rst_req,
  // To the supervisor
  output logic running,
  output logic keypad_reset
);
  // Operation stops one cycle after gating, as the bridge reports it late
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      running <= 1'b0;
      keypad_reset <= 1'b0;
    end else begin
      running <= run_cmd && !out_block;
      keypad_reset <= rst_req;
    end
  end
endmodule : dps_drive_model

// >>> test/dps_supervisor_props.sv
// Port-level checks for the drive protection supervisor
`timescale 1ns/1ns
module dps_supervisor_props import dps_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Drive side
  input wire logic over_temp,
  input wire logic dc_bus_low,
  input wire logic out_block,
  input wire logic accel_enable,
  input wire logic [2:0] mfo
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> bvalid && !awready)
    else $error("write answer missing");
  a_rd_answer: assert property (s_rd_take |=> rvalid && !arready)
    else $error("read answer missing");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  a_rd_unmapped: assert property (arvalid && arready && araddr == 8'h3C
    |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_rd_reopen: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");
  a_reset_idle: assert property ($rose(aresetn) |-> !out_block && !bvalid
    && !rvalid && awready && arready && mfo == 3'h0)
    else $error("outputs not idle after reset");
  a_uv_block: assert property (dc_bus_low |=> out_block)
    else $error("low bus did not block");
  a_heat_block: assert property (over_temp |=> out_block)
    else $error("overheat did not block");
  a_blk_noaccel: assert property (out_block |-> !accel_enable)
    else $error("accelerating while blocked");
endmodule : dps_supervisor_props
bind dps_supervisor dps_supervisor_props u_props (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .over_temp,
  .dc_bus_low, .out_block, .accel_enable, .mfo);

// >>> test/drive_protection_supervisor_tb_top.sv
// Scenario bench for the drive protection supervisor
`timescale 1ns/1ns
module drive_protection_supervisor_tb_top import dps_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, rst_req = 1'b0, run_cmd = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, esave_active = 1'b0;
  logic [AW-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [15:0] out_freq = 16'd6000, out_current = 16'h0, rated_slip = 16'd100;
  logic [15:0] base_freq = 16'd6000, motor_speed = 16'h0, speed_dev = 16'h0;
  logic [7:0] current_pct = 8'd50, load_pct = 8'd50, mfi_pins = 8'h00;
  logic enc_card_present = 1'b1, enc_line_lost = 1'b0, fan_fault = 1'b0;
  logic over_temp = 1'b0, dc_bus_low = 1'b0, opt_fault = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, running, keypad_reset;
  logic out_block, ramp_stop, accel_enable, ul_warn;
  logic [1:0] bresp, rresp, rr;
  logic [15:0] ramp_time;
  logic [2:0] mfo;
  int miscompares = 0, n_checks = 0;
  always_comb ul_warn = mfo[1];
  dps_supervisor #(.TICK_CYCLES(10)) dut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .run_cmd, .running, .esave_active, .out_freq, .out_current,
    .current_pct, .load_pct, .rated_slip, .base_freq, .motor_speed,
    .speed_dev, .enc_card_present, .enc_line_lost, .fan_fault, .over_temp,
    .dc_bus_low, .opt_fault, .keypad_reset, .mfi_pins, .out_block,
    .ramp_stop, .ramp_time, .accel_enable, .mfo);
  dps_drive_model model (.aclk, .aresetn, .out_block, .run_cmd, .rst_req,
    .running, .keypad_reset);
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic give_up();
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask : give_up
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wait_hi(ref logic s, input int n);
    int i;
    for (i = 0; i < n && s !== 1'b1; i++) @(posedge aclk);
    if (i == n) give_up();
  endtask : wait_hi
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 50) give_up();
    chk(bresp, e);
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (i == 50) give_up();
    @(posedge aclk);
  endtask : axi_rd
  task automatic clr();
    rst_req <= 1'b1;
    cyc(3);
    rst_req <= 1'b0;
    cyc(3);
  endtask : clr
  task automatic t_regs();
    axi_rd(A_CTRL);
    chk(rd, CTRL_RST);
    axi_rd(A_ULDLY);
    chk(rd, ULDLY_RST);
    axi_rd(A_STOP);
    chk(rd, STOP_RST);
    axi_wr(A_ULRAT, 32'h0000_FF05, RESP_OKAY);
    axi_rd(A_ULRAT);
    chk(rd, 32'h0000_640A);
    axi_wr(A_STAT, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_rd(8'h3C);
    chk(rr, RESP_SLVERR);
    axi_wr(A_ULRAT, ULRAT_RST, RESP_OKAY);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_uv();
    axi_wr(A_OFUNC, 32'h0008_060B, RESP_OKAY);
    run_cmd <= 1'b1;
    cyc(5);
    dc_bus_low <= 1'b1;
    cyc(2);
    chk(out_block, 1'b1);
    chk(mfo[0], 1'b1);
    dc_bus_low <= 1'b0;
    cyc(5);
    chk(out_block, 1'b1);
    axi_rd(A_STAT);
    chk(rd[6], 1'b1);
    clr();
    chk(out_block, 1'b0);
    $display("t_uv done");
  endtask : t_uv
  task automatic t_fan();
    axi_wr(A_CTRL, CTRL_RST | 32'h40, RESP_OKAY);
    fan_fault <= 1'b1;
    cyc(3);
    chk(out_block, 1'b0);
    chk(mfo[2], 1'b1);
    over_temp <= 1'b1;
    cyc(3);
    over_temp <= 1'b0;
    fan_fault <= 1'b0;
    clr();
    axi_wr(A_CTRL, CTRL_RST, RESP_OKAY);
    axi_wr(A_IFUNC, 32'h0000_0053, RESP_OKAY);
    fan_fault <= 1'b1;
    cyc(3);
    chk(out_block, 1'b1);
    fan_fault <= 1'b0;
    axi_rd(A_STAT);
    chk(rd[4], 1'b1);
    chk(out_block, 1'b1);
    mfi_pins <= 8'h01;
    cyc(3);
    mfi_pins <= 8'h00;
    cyc(3);
    chk(out_block, 1'b0);
    $display("t_fan done");
  endtask : t_fan
  task automatic t_block();
    out_freq <= 16'h1234;
    out_current <= 16'h0567;
    cyc(5);
    mfi_pins <= 8'h02;
    cyc(3);
    chk(out_block, 1'b1);
    axi_rd(A_STAT);
    chk(rd[10], 1'b1);
    axi_rd(A_CAPT);
    chk(rd, 32'h0567_1234);
    mfi_pins <= 8'h00;
    cyc(5);
    chk(accel_enable, 1'b1);
    axi_wr(A_STOP, 32'h001E_0005, RESP_OKAY);
    mfi_pins <= 8'h02;
    cyc(3);
    chk(out_block, 1'b0);
    chk(ramp_stop, 1'b1);
    chk(ramp_time, 16'h0005);
    mfi_pins <= 8'h00;
    out_freq <= 16'd6000;
    axi_wr(A_STOP, STOP_RST, RESP_OKAY);
    $display("t_block done");
  endtask : t_block
  task automatic t_ul();
    // Warning after 0.1 s (100 cycles here), fault after 0.2 s
    axi_wr(A_ULDLY, 32'h0002_0001, RESP_OKAY);
    axi_wr(A_CTRL, CTRL_RST ^ 32'h3, RESP_OKAY);
    esave_active <= 1'b1;
    load_pct <= 8'd5;
    cyc(400);
    chk(ul_warn, 1'b0);
    chk(ramp_stop, 1'b0);
    esave_active <= 1'b0;
    cyc(80);
    load_pct <= 8'd50;
    cyc(2);
    load_pct <= 8'd5;
    cyc(60);
    chk(ul_warn, 1'b0);
    wait_hi(ul_warn, 200);
    chk(ul_warn, 1'b1);
    wait_hi(ramp_stop, 300);
    chk(out_block, 1'b0);
    chk(ramp_time, 16'd30);
    load_pct <= 8'd50;
    clr();
    axi_wr(A_CTRL, CTRL_RST, RESP_OKAY);
    load_pct <= 8'd5;
    wait_hi(out_block, 400);
    chk(out_block, 1'b1);
    load_pct <= 8'd50;
    clr();
    $display("t_ul done");
  endtask : t_ul
  task automatic t_trip();
    int a;
    motor_speed <= 16'd13000;
    cyc(50);
    chk(out_block, 1'b0);
    axi_wr(A_CTRL, CTRL_RST | 32'h8, RESP_OKAY);
    wait_hi(out_block, 100);
    chk(out_block, 1'b1);
    motor_speed <= 16'h0;
    clr();
    for (a = 0; a < 3; a++) begin
      axi_wr(A_CTRL, (CTRL_RST & ~32'h180) | (a << 7), RESP_OKAY);
      opt_fault <= 1'b1;
      cyc(3);
      chk(out_block, a == 1);
      chk(ramp_stop, a == 2);
      opt_fault <= 1'b0;
      clr();
    end
    $display("t_trip done");
  endtask : t_trip
  task automatic t_sense();
    // Threshold is 55 % halfway between twice the slip and base
    axi_wr(A_ULRAT, 32'h0000_640A, RESP_OKAY);
    out_freq <= 16'd200;
    load_pct <= 8'd54;
    cyc(150);
    chk(ul_warn, 1'b0);
    out_freq <= 16'd3100;
    wait_hi(ul_warn, 150);
    chk(ul_warn, 1'b1);
    load_pct <= 8'd56;
    cyc(2);
    chk(ul_warn, 1'b0);
    load_pct <= 8'd50;
    out_freq <= 16'd6000;
    axi_wr(A_ULRAT, ULRAT_RST, RESP_OKAY);
    axi_wr(A_ENCUV, 32'h0000_0001, RESP_OKAY);
    enc_line_lost <= 1'b1;
    cyc(50);
    chk(out_block, 1'b0);
    wait_hi(out_block, 200);
    chk(out_block, 1'b1);
    enc_line_lost <= 1'b0;
    clr();
    axi_wr(A_SDEV, 32'h0001_07D0, RESP_OKAY);
    speed_dev <= 16'd2100;
    cyc(150);
    chk(out_block, 1'b0);
    axi_wr(A_CTRL, CTRL_RST | 32'h8, RESP_OKAY);
    wait_hi(out_block, 200);
    chk(out_block, 1'b1);
    speed_dev <= 16'h0;
    clr();
    axi_wr(A_NOMOT, 32'h0001_0005, RESP_OKAY);
    axi_wr(A_CTRL, CTRL_RST | 32'h200, RESP_OKAY);
    current_pct <= 8'd3;
    wait_hi(out_block, 200);
    chk(out_block, 1'b1);
    current_pct <= 8'd50;
    axi_wr(A_CMD, 32'h0000_0001, RESP_OKAY);
    cyc(2);
    chk(out_block, 1'b0);
    $display("t_sense done");
  endtask : t_sense
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_regs();
    t_uv();
    t_fan();
    t_block();
    t_ul();
    t_trip();
    t_sense();
    close_out();
  end
endmodule : drive_protection_supervisor_tb_top
